// >>> design/iadm_map.svh
`ifndef IADM_MAP_SVH
`define IADM_MAP_SVH
// runtime register slots in isa i/o space
`define IADM_CHANNEL0_CURRENT_ADDRESS 4'h0
`define IADM_CHANNEL0_BYTE_COUNT 4'h1
`define IADM_STAT_CMD 4'h8
`define IADM_REQ 4'h9
`define IADM_SMASK 4'hA
`define IADM_MODE 4'hB
`define IADM_BPTR_CLR 4'hC
`define IADM_MCLR 4'hD
`define IADM_CLR_MASK 4'hE
`define IADM_ALL_MASK 4'hF
// dma core address fields
`define IADM_TGT_BIT 15
`define IADM_PKT_HI 14
`define IADM_PKT_LO 10
`define IADM_OFF_HI 9
`define IADM_PG_HI 9
`define IADM_PG_LO 7
// limits
`define IADM_XFER_MAX 1024
`define IADM_HDR_BYTES 8
`define IADM_EXT_CH_MIN 2
// reset values
`define IADM_MASK_RST 4'hF
`define IADM_BASE_RST 8'h00
`endif

// >>> design/iadm_pkg.sv
package iadm_pkg;
    typedef enum logic [1:0] {
        IADM_IDLE,
        IADM_REQ,
        IADM_WAIT
    } iadm_state_t;
    typedef logic [15:0] iadm_word_t;
endpackage : iadm_pkg

// >>> design/iadm_top.sv
`timescale 1ns/1ps
`include "iadm_map.svh"
// Function
// R1 - upper half maps to 32 one-kilobyte packet windows
// R2 - lower half goes to external 32K window
// R3 - address bit 15 selects target
// R4 - bits 14..10 packet number or external address
// R5 - bits 9..0 offset or external address
// R6 - external accesses drive high address bits low
// R7 - internal accesses force offset bit ten low
// R8 - one transfer never exceeds 1024 bytes; the 16-bit count register is not limited to it here
// R9 - external target allowed only on channels 2, 3
// R10 - remap packet pages onto physical 128-byte pages
// R11 - each channel programmed independently, sharing allowed
// R12 - sixteen runtime registers at i/o 0x00-0x0F
// R13 - controller reaches them through window base zero
// R14 - register writes only while grant is low
// R15 - slots: channel pairs, then command/mask/clear registers
// R16 - channel 0 address, byte by pointer
// R17 - channel 0 count, byte by pointer
// R18 - software clears pointer before address/count writes
// R19 - pointer toggles per access, cleared by commands
// R20 - window base supplies i/o address bits 15..8

// ----------------------------------------------------------
// data fifo
// ----------------------------------------------------------
module iadm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rp_q];
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + AW'(1);
            if (pop) rp_q <= rp_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : iadm_fifo

// ----------------------------------------------------------
// address map and runtime registers
// ----------------------------------------------------------
module iadm_top #(
    parameter int CHANS = 4,
    parameter int PAGES = 10,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic bus_grant_ack_i,
    input wire logic base_wr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_off_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    input wire logic map_wr_i,
    input wire logic [4:0] map_pkt_i,
    input wire logic [3:0] map_slot_i,
    input wire logic [4:0] map_page_i,
    input wire logic [3:0] dreq_i,
    output logic mem_req_o,
    output logic mem_ext_o,
    output logic [19:0] mem_addr_o,
    input wire logic mem_rvalid_i,
    input wire logic [7:0] mem_rdata_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [7:0] out_data_o,
    output logic [3:0] tc_o
);
    iadm_pkg::iadm_state_t st_q;
    iadm_pkg::iadm_word_t addr_q [CHANS];
    iadm_pkg::iadm_word_t cnt_q [CHANS];
    logic [4:0] page_q [32][PAGES];
    logic [7:0] io_window_base_q;
    logic byte_ptr_q;
    logic [7:0] cmd_q;
    logic [3:0] mask_q;
    logic [3:0] sreq_q;
    logic [3:0] tcst_q;
    logic [7:0] mode_q [CHANS];
    logic [1:0] ch_q;

    // --------------------------------------------------------
    // register decode
    // --------------------------------------------------------
    wire [15:0] io_addr = {io_window_base_q, io_off_i}; // [R20]
    wire io_hit = io_addr[15:4] == 12'h000; // [R12] [R13]
    wire [3:0] slot = io_addr[3:0];
    wire wr_hit = io_wr_i & io_hit & ~bus_grant_ack_i; // [R14]
    wire rd_hit = io_rd_i & io_hit;
    wire chan_slot = ~slot[3]; // [R15]
    wire [1:0] sch = slot[2:1];
    wire is_cnt = slot[0];
    wire chan_acc = (wr_hit | rd_hit) & chan_slot;
    wire mclr = wr_hit & slot == `IADM_MCLR;
    wire bclr = wr_hit & slot == `IADM_BPTR_CLR;
    wire stat_rd = rd_hit & slot == `IADM_STAT_CMD;
    wire [15:0] sel_reg = is_cnt ? cnt_q[sch] : addr_q[sch];
    wire [7:0] sel_byte = byte_ptr_q ? sel_reg[15:8] : sel_reg[7:0];
    wire [7:0] rd_mux = chan_slot ? sel_byte :
        (slot == `IADM_STAT_CMD) ? {dreq_i | sreq_q, tcst_q} : 8'h00;

    // --------------------------------------------------------
    // translation
    // --------------------------------------------------------
    function automatic logic ch_ok(input logic [1:0] ch,
                                   input logic [15:0] a);
        ch_ok = a[`IADM_TGT_BIT] |
            (ch >= 2'(`IADM_EXT_CH_MIN)); // [R9]
    endfunction : ch_ok

    wire [3:0] want = (dreq_i | sreq_q) & ~mask_q;
    logic [3:0] elig;
    always_comb begin
        for (int i = 0; i < CHANS; i++) begin
            elig[i] = want[i] & ch_ok(2'(i), addr_q[i]);
        end
    end
    wire [1:0] pick = elig[0] ? 2'd0 : elig[1] ? 2'd1 :
        elig[2] ? 2'd2 : 2'd3;
    wire [15:0] cur = addr_q[pick]; // [R11]
    wire tgt_int = cur[`IADM_TGT_BIT]; // [R3]
    wire [4:0] pkt = cur[`IADM_PKT_HI:`IADM_PKT_LO]; // [R1] [R4]
    // bit ten of the offset is never taken from the address
    wire [10:0] off = {1'b0, cur[`IADM_OFF_HI:0]}; // [R5] [R7] [R8]
    wire [4:0] phys = page_q[pkt][4'(off[`IADM_PG_HI:`IADM_PG_LO])];
    wire [19:0] int_addr = {8'h00, phys, off[6:0]}; // [R10]
    wire [19:0] ext_addr = {5'b00000, cur[14:0]}; // [R2] [R6]
    always_ff @(posedge sys_clk_i) begin
        if (map_wr_i && map_slot_i < 4'(PAGES)) begin // [R10]
            page_q[map_pkt_i][map_slot_i] <= map_page_i;
        end
    end

    // --------------------------------------------------------
    // fifo and output stage
    // --------------------------------------------------------
    logic f_ready;
    logic f_valid;
    logic [7:0] f_data;
    wire push = (st_q == iadm_pkg::IADM_WAIT) & mem_rvalid_i;
    wire stage_free = ~out_valid_o | out_ready_i;
    iadm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(push),
        .in_ready_o(f_ready),
        .in_data_i(mem_rdata_i),
        .out_valid_o(f_valid),
        .out_ready_i(stage_free),
        .out_data_o(f_data)
    );
    // start only with room, so a returning byte always fits
    wire start = (st_q == iadm_pkg::IADM_IDLE) & bus_grant_ack_i &
        (|elig) & f_ready;
    wire [15:0] cnt_cur = cnt_q[ch_q];
    wire hit_tc = push & cnt_cur == 16'h0000;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= 8'h00;
        end else if (stage_free) begin
            out_valid_o <= f_valid;
            out_data_o <= f_data;
        end
    end

    // --------------------------------------------------------
    // transfer sequencer
    // --------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= iadm_pkg::IADM_IDLE;
            ch_q <= 2'd0;
            mem_req_o <= 1'b0;
            mem_ext_o <= 1'b0;
            mem_addr_o <= 20'h00000;
        end else begin
            mem_req_o <= start;
            unique case (st_q)
                iadm_pkg::IADM_IDLE: begin
                    if (start) begin
                        st_q <= iadm_pkg::IADM_REQ;
                        ch_q <= pick;
                        mem_ext_o <= ~tgt_int;
                        mem_addr_o <= tgt_int ? int_addr : ext_addr;
                    end
                end
                iadm_pkg::IADM_REQ: st_q <= iadm_pkg::IADM_WAIT;
                iadm_pkg::IADM_WAIT: begin
                    if (mem_rvalid_i) st_q <= iadm_pkg::IADM_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // runtime registers
    // --------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < CHANS; i++) begin
                addr_q[i] <= 16'h0000;
                cnt_q[i] <= 16'h0000;
                mode_q[i] <= 8'h00;
            end
            io_window_base_q <= `IADM_BASE_RST;
            byte_ptr_q <= 1'b0;
            cmd_q <= 8'h00;
            mask_q <= `IADM_MASK_RST;
            sreq_q <= 4'h0;
            tcst_q <= 4'h0;
            io_rdata_o <= 8'h00;
            tc_o <= 4'h0;
        end else begin
            tc_o <= 4'h0;
            if (base_wr_i) io_window_base_q <= io_wdata_i;
            if (rd_hit) io_rdata_o <= rd_mux;
            if (bclr | mclr) begin
                byte_ptr_q <= 1'b0; // [R19]
            end else if (chan_acc) begin
                byte_ptr_q <= ~byte_ptr_q; // [R19]
            end
            if (wr_hit & chan_slot) begin // [R16] [R17]
                if (is_cnt & byte_ptr_q) cnt_q[sch][15:8] <= io_wdata_i;
                if (is_cnt & ~byte_ptr_q) cnt_q[sch][7:0] <= io_wdata_i;
                if (~is_cnt & byte_ptr_q) addr_q[sch][15:8] <= io_wdata_i;
                if (~is_cnt & ~byte_ptr_q) addr_q[sch][7:0] <= io_wdata_i;
            end
            if (wr_hit & slot == `IADM_STAT_CMD) cmd_q <= io_wdata_i;
            if (wr_hit & slot == `IADM_REQ) begin
                sreq_q[io_wdata_i[1:0]] <= io_wdata_i[2];
            end
            if (wr_hit & slot == `IADM_SMASK) begin
                mask_q[io_wdata_i[1:0]] <= io_wdata_i[2];
            end
            if (wr_hit & slot == `IADM_MODE) begin
                mode_q[io_wdata_i[1:0]] <= io_wdata_i;
            end
            if (wr_hit & slot == `IADM_CLR_MASK) mask_q <= 4'h0;
            if (wr_hit & slot == `IADM_ALL_MASK) begin
                mask_q <= io_wdata_i[3:0];
            end
            // status read clears, but a count ending now survives
            if (stat_rd) tcst_q <= 4'h0;
            if (mclr) begin
                cmd_q <= 8'h00;
                mask_q <= `IADM_MASK_RST;
                sreq_q <= 4'h0;
                tcst_q <= 4'h0;
            end
            if (push) begin
                addr_q[ch_q] <= addr_q[ch_q] + 16'h0001;
                cnt_q[ch_q] <= cnt_q[ch_q] - 16'h0001;
            end
            if (hit_tc) begin
                tcst_q[ch_q] <= 1'b1;
                mask_q[ch_q] <= 1'b1;
                sreq_q[ch_q] <= 1'b0;
                tc_o[ch_q] <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------
    // checks
    // --------------------------------------------------------
    ext_high_zero_a: assert property ( // [R6]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        mem_req_o && mem_ext_o |-> mem_addr_o[19:15] == 5'b00000)
        else $error("external address high bits not low");
    int_window_a: assert property ( // [R10]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        mem_req_o && !mem_ext_o |-> mem_addr_o[19:12] == 8'h00)
        else $error("internal address outside buffer");
    target_sel_a: assert property ( // [R3]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        start |=> mem_ext_o == !$past(cur[15]))
        else $error("target select does not follow bit 15");
    ext_chan_a: assert property ( // [R9]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        mem_req_o && mem_ext_o |-> ch_q >= 2'd2)
        else $error("external transfer on channel 0 or 1");
    grant_gate_a: assert property ( // [R14]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        io_wr_i && bus_grant_ack_i |=> $stable(cmd_q) && $stable(mode_q[0]))
        else $error("register written during grant");
    ptr_toggle_a: assert property ( // [R19]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        chan_acc && !bclr && !mclr |=> byte_ptr_q != $past(byte_ptr_q))
        else $error("byte pointer failed to toggle");
    ptr_clear_a: assert property ( // [R19]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        bclr ##1 (wr_hit && slot == 4'h0) |=> addr_q[0][7:0] == $past(io_wdata_i))
        else $error("first byte after clear missed low byte");
    tc_status_a: assert property ( // [R8]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        hit_tc |=> tcst_q[$past(ch_q)] && mask_q[$past(ch_q)])
        else $error("terminal count not recorded");
    req_seq_a: assert property ( // [R11]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        start |=> mem_req_o ##1 !mem_req_o)
        else $error("memory request not a single pulse");
endmodule : iadm_top

// >>> tb/iadm_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// isa memory and packet buffer responder
// ----------------------------------------------------------
module iadm_mem_model #(
    parameter int LAT = 3
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic mem_req_i,
    input wire logic [19:0] mem_addr_i,
    output logic mem_rvalid_o,
    output logic [7:0] mem_rdata_o
);
    logic [3:0] wait_q;
    logic busy_q;
    logic [7:0] data_q;
    logic [7:0] last_q;
    // data depends on the low offset bits only, so a page remap keeps it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_q <= 1'b0;
            wait_q <= 4'h0;
            data_q <= 8'h00;
            mem_rvalid_o <= 1'b0;
        end else begin
            mem_rvalid_o <= 1'b0;
            if (mem_req_i) begin
                busy_q <= 1'b1;
                wait_q <= 4'(LAT);
                data_q <= {1'b0, mem_addr_i[6:0]} ^ 8'hC3;
            end else if (busy_q && wait_q == 4'h0) begin
                busy_q <= 1'b0;
                mem_rvalid_o <= 1'b1;
            end else if (busy_q) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (mem_rvalid_o) begin
            last_q <= mem_rdata_o;
        end
    end
    // a released data line shows the inverse, never a stale match
    assign mem_rdata_o = mem_rvalid_o ? data_q : ~last_q;
endmodule : iadm_mem_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic sys_clk_i, nrst_i, bus_grant_ack_i, base_wr_i, io_rd_i, io_wr_i;
    logic [7:0] io_off_i, io_wdata_i, io_rdata_o, mem_rdata_i, out_data_o;
    logic [3:0] dreq_i, tc_o;
    logic mem_req_o, mem_ext_o, mem_rvalid_i, out_valid_o, out_ready_i;
    logic [19:0] mem_addr_o;
    logic map_wr_i;
    logic [4:0] map_pkt_i, map_page_i;
    logic [3:0] map_slot_i;
    int n_mismatch = 0;
    int checked = 0;
    iadm_top u_iadm_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .bus_grant_ack_i(bus_grant_ack_i), .base_wr_i(base_wr_i),
        .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_off_i(io_off_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .map_wr_i(map_wr_i), .map_pkt_i(map_pkt_i),
        .map_slot_i(map_slot_i), .map_page_i(map_page_i),
        .dreq_i(dreq_i), .mem_req_o(mem_req_o),
        .mem_ext_o(mem_ext_o), .mem_addr_o(mem_addr_o),
        .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
        .out_data_o(out_data_o), .tc_o(tc_o));
    iadm_mem_model u_iadm_mem_model (.sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
        .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // ----------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic chk(string name, logic [19:0] exp, logic [19:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic io_wr(logic [7:0] off, logic [7:0] data);
        io_wr_i = 1'b1;
        io_off_i = off;
        io_wdata_i = data;
        @(posedge sys_clk_i);
        #1 io_wr_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask : io_wr
    task automatic base_wr(logic [7:0] data);
        base_wr_i = 1'b1;
        io_wdata_i = data;
        @(posedge sys_clk_i);
        #1 base_wr_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask : base_wr
    task automatic map_wr(logic [4:0] pkt, logic [3:0] slot,
                          logic [4:0] page);
        map_wr_i = 1'b1;
        map_pkt_i = pkt;
        map_slot_i = slot;
        map_page_i = page;
        @(posedge sys_clk_i);
        #1 map_wr_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask : map_wr
    task automatic io_rd(logic [7:0] off, logic [7:0] exp, string name);
        io_rd_i = 1'b1;
        io_off_i = off;
        @(posedge sys_clk_i);
        #1 io_rd_i = 1'b0;
        @(posedge sys_clk_i);
        #1 chk(name, {12'h000, exp}, {12'h000, io_rdata_o});
    endtask : io_rd
    // program one channel, run one byte and check address and data
    task automatic xfer(int ch, logic [15:0] a, logic go, logic ext,
                        logic [19:0] msk, logic [19:0] ea, logic [7:0] ed);
        int i;
        logic seen;
        logic [3:0] tcs;
        logic [3:0] tc_exp;
        seen = 1'b0;
        tcs = 4'h0;
        // count zero means the single byte ends the count
        tc_exp = go ? 4'(1 << ch) : 4'h0;
        io_wr(8'h0C, 8'h00);
        io_wr(8'(2 * ch), a[7:0]);
        io_wr(8'(2 * ch), a[15:8]);
        io_wr(8'(2 * ch + 1), 8'h00);
        io_wr(8'(2 * ch + 1), 8'h00);
        io_wr(8'h0A, 8'(ch));
        bus_grant_ack_i = 1'b1;
        out_ready_i = 1'b0;
        dreq_i[ch] = 1'b1;
        for (i = 0; i < 40 && !seen; i++) begin
            @(posedge sys_clk_i);
            #1 seen = mem_req_o;
        end
        chk("serviced", {19'h0, go}, {19'h0, seen});
        if (seen) begin
            chk("target", {19'h0, ext}, {19'h0, mem_ext_o});
            chk("address", ea, mem_addr_o & msk);
        end
        dreq_i[ch] = 1'b0;
        repeat (8) begin
            @(posedge sys_clk_i);
            #1 tcs = tcs | tc_o;
        end
        out_ready_i = 1'b1;
        if (go) begin
            for (i = 0; i < 40 && out_valid_o !== 1'b1; i++) begin
                @(posedge sys_clk_i);
                #1;
            end
            if (i == 40) begin
                n_mismatch++;
                results();
            end
            chk("stream data", {12'h000, ed}, {12'h000, out_data_o});
        end
        chk("terminal count", {16'h0000, tc_exp}, {16'h0000, tcs});
        repeat (4) @(posedge sys_clk_i);
        #1 bus_grant_ack_i = 1'b0;
        io_rd(8'h08, {4'h0, tc_exp}, "status");
        io_wr(8'h0A, 8'(4 + ch));
    endtask : xfer
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        nrst_i = 1'b0;
        {bus_grant_ack_i, base_wr_i, io_rd_i, io_wr_i} = 4'h0;
        {io_off_i, io_wdata_i, dreq_i} = 20'h00000;
        {map_wr_i, map_pkt_i, map_slot_i, map_page_i} = 15'h0000;
        out_ready_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1 nrst_i = 1'b1;
        chk("outputs after reset", 20'h00000,
            {6'h00, io_rdata_o, mem_req_o, out_valid_o, tc_o});
        io_wr(8'h0C, 8'h00);
        io_wr(8'h00, 8'h34);
        io_wr(8'h00, 8'h12);
        io_wr(8'h01, 8'h05);
        io_wr(8'h01, 8'h00);
        io_wr(8'h0C, 8'h00);
        io_rd(8'h00, 8'h34, "address low");
        io_rd(8'h00, 8'h12, "address high");
        io_rd(8'h01, 8'h05, "count low");
        io_rd(8'h01, 8'h00, "count high");
        // write while granted must be dropped
        bus_grant_ack_i = 1'b1;
        io_wr(8'h0C, 8'h00);
        io_wr(8'h00, 8'hFF);
        bus_grant_ack_i = 1'b0;
        io_wr(8'h0C, 8'h00);
        io_rd(8'h00, 8'h34, "granted write");
        // a nonzero window base moves the access off the registers
        base_wr(8'h01);
        io_wr(8'h0C, 8'h00);
        io_wr(8'h00, 8'h77);
        base_wr(8'h00);
        io_wr(8'h0C, 8'h00);
        io_rd(8'h00, 8'h34, "window base");
        io_wr(8'h0D, 8'h00);
        io_rd(8'h00, 8'h34, "pointer after master clear");
        xfer(2, 16'h1234, 1'b1, 1'b1, 20'hFFFFF, 20'h01234, 8'hF7);
        map_wr(5'h0B, 4'h0, 5'h15);
        xfer(3, 16'hAC27, 1'b1, 1'b0, 20'hFFFFF, 20'h00AA7, 8'hE4);
        map_wr(5'h1F, 4'h7, 5'h09);
        xfer(1, 16'hFFFF, 1'b1, 1'b0, 20'hFFFFF, 20'h004FF, 8'hBC);
        xfer(0, 16'h0100, 1'b0, 1'b1, 20'hFFFFF, 20'h00100, 8'h00);
        results();
    end
endmodule : tb_top
